// file: verilog/ncr_pkg.sv
/*
 package for the nibble control register file: address fields, control
 register layout, per-location attribute tables, and the core request carrier.
 assumes a single clock domain shared with the processor core.
*/
package ncr_pkg;

    // ------------------------------------------------------------
    // address layout
    // ------------------------------------------------------------
    localparam int ADDR_W    = 7;
    localparam int ROW_W     = 3;
    localparam int COL_W     = 4;
    localparam int NIB_W     = 4;
    localparam int DEPTH     = 128;
    localparam int CTRL_LOCS = 64;
    localparam int ALIAS_BIT = 6;
    localparam logic [ADDR_W-1:0] CTRL_LO  = 7'h00;
    localparam logic [ADDR_W-1:0] CTRL_HI  = 7'h3f;
    localparam logic [ADDR_W-1:0] ALIAS_LO = 7'h40;
    localparam logic [ADDR_W-1:0] ALIAS_HI = 7'h7f;
    localparam logic [ADDR_W-1:0] XFER_LATCH_ADDR = 7'h78;

    // ------------------------------------------------------------
    // control register special locations
    // ------------------------------------------------------------
    localparam logic [5:0] TMR_RESTART_ADDR = 6'h11;
    localparam int         TMR_RESTART_BIT  = 2;
    localparam logic [NIB_W-1:0] CTRL_RESET_VAL = 4'h0;
    localparam logic [NIB_W-1:0] UNUSED_READ_VAL = 4'h0;

    // per-location attributes: implemented, writable, and bit masks
    typedef struct packed {
        logic             impl;
        logic             wr;
        logic [NIB_W-1:0] live;   // bits not fixed at zero
        logic [NIB_W-1:0] wonly;  // writable bits that always read zero
    } ncr_attr_t;

    // core request carrier
    typedef struct packed {
        logic              rd;    // config_read_op
        logic              wr;    // config_write_op
        logic [ADDR_W-1:0] addr;  // {row, column}
        logic [NIB_W-1:0]  latch; // transfer latch contents for a write
    } ncr_req_t;

    // data memory port towards the aliased upper half
    typedef struct packed {
        logic             we;
        logic [5:0]       addr;   // offset within 40h..7fh
        logic [NIB_W-1:0] wdata;
    } ncr_dm_t;

endpackage

// file: verilog/ncr_cell.sv
/*
 one control register nibble with write mask and fixed-zero read mask.
 assumes the caller decodes the address and supplies a one-cycle write pulse.
*/
`timescale 1ns/1ps
module ncr_cell #(
    parameter logic [3:0] LIVE  = 4'hf,
    parameter logic [3:0] WONLY = 4'h0
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       we,
    input  wire logic [3:0] wdata,
    output logic      [3:0] q,
    output logic      [3:0] rdata
);
    assign rdata = q & ~WONLY;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            q <= ncr_pkg::CTRL_RESET_VAL;
        end else if (we) begin
            q <= wdata & LIVE;
        end
    end
endmodule

// file: verilog/ncr_regfile.sv
/*
 nibble control register file: 64 control nibbles plus a 64-nibble window
 onto data memory, reached by the core's dedicated read and write operations
 through the one-nibble transfer latch.
 assumes the core presents one request per cycle and owns the transfer latch;
 data memory lives outside and answers reads combinationally in the same cycle.
*/
`timescale 1ns/1ps
module ncr_regfile #(
    parameter bit LARGE = 1'b1,
    parameter logic [63:0] IMPL_SMALL = 64'h0000_0000_001f_0fff,
    parameter logic [63:0] IMPL_LARGE = 64'h0000_0000_007f_1fff,
    parameter logic [63:0] WR_MAP     = 64'h0000_0000_0037_0fff
) (
    input  wire logic                                 mclk,
    input  wire logic                                 rst_n,
    input  wire ncr_pkg::ncr_req_t                    req,
    input  wire logic [ncr_pkg::NIB_W-1:0]            dm_rdata,
    input  wire logic [ncr_pkg::NIB_W-1:0]            ro_status [ncr_pkg::CTRL_LOCS],
    output ncr_pkg::ncr_dm_t                          dm,
    output logic                                      latch_we,
    output logic [ncr_pkg::NIB_W-1:0]                 latch_data,
    output logic [ncr_pkg::CTRL_LOCS*ncr_pkg::NIB_W-1:0] ctrl_out
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    localparam logic [63:0] IMPL = LARGE ? IMPL_LARGE : IMPL_SMALL;

    wire       is_alias = req.addr[ncr_pkg::ALIAS_BIT];
    wire [5:0] idx      = req.addr[5:0];
    wire [ncr_pkg::ROW_W-1:0] row = req.addr[6:4];
    wire [ncr_pkg::COL_W-1:0] col = req.addr[3:0];
    wire       hit_impl = IMPL[idx];
    wire       hit_wr   = WR_MAP[idx] & hit_impl;
    wire       ctrl_we  = req.wr & ~is_alias & hit_wr;

    logic [ncr_pkg::NIB_W-1:0] cell_rd [ncr_pkg::CTRL_LOCS];

    // ------------------------------------------------------------
    // control nibbles: only the dedicated ops reach them
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < ncr_pkg::CTRL_LOCS; g++) begin : g_cell
            localparam logic [3:0] WO = (g == ncr_pkg::TMR_RESTART_ADDR) ?
                                        4'h4 : 4'h0;
            if (IMPL[g] && WR_MAP[g]) begin : g_rw
                ncr_cell #(.LIVE(4'hf), .WONLY(WO)) u_cell (
                    .mclk  (mclk),
                    .rst_n (rst_n),
                    .we    (ctrl_we && idx == 6'(g)),
                    .wdata (req.latch),
                    .q     (ctrl_out[g*4 +: 4]),
                    .rdata (cell_rd[g])
                );
            end else if (IMPL[g]) begin : g_ro
                assign cell_rd[g] = ro_status[g];
                assign ctrl_out[g*4 +: 4] = 4'h0;
            end else begin : g_unused
                assign cell_rd[g] = ncr_pkg::UNUSED_READ_VAL;
                assign ctrl_out[g*4 +: 4] = 4'h0;
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // read mux and aliased memory port
    // ------------------------------------------------------------
    wire [3:0] rd_val = is_alias ? dm_rdata : cell_rd[idx];

    assign dm.we    = req.wr & is_alias;
    assign dm.addr  = idx;
    assign dm.wdata = req.latch;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latch_we   <= 1'b0;
            latch_data <= 4'h0;
        end else begin
            latch_we   <= req.rd;
            latch_data <= rd_val;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_read_latch: assert property (@(posedge mclk) disable iff (!rst_n)
        req.rd && is_alias |=> latch_we && latch_data == $past(dm_rdata))
        else $error("read did not load latch");
    a_alias_write: assert property (@(posedge mclk) disable iff (!rst_n)
        dm.we |-> req.addr[6] && req.wr)
        else $error("stray memory write");
    a_tmr_reads_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        req.rd && !is_alias && idx == ncr_pkg::TMR_RESTART_ADDR |=> !latch_data[2])
        else $error("restart flag read nonzero");
    a_unused_still: assert property (@(posedge mclk) disable iff (!rst_n)
        req.wr && !is_alias && !hit_impl |=> $stable(ctrl_out))
        else $error("unused write changed state");
    a_ro_still: assert property (@(posedge mclk) disable iff (!rst_n)
        req.wr && !is_alias && hit_impl && !WR_MAP[idx] |=> $stable(ctrl_out))
        else $error("read-only write changed state");
    a_no_latch_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        !req.rd |=> !latch_we)
        else $error("latch loaded without read");
    a_ctrl_write: assert property (@(posedge mclk) disable iff (!rst_n)
        ctrl_we && idx == 6'h00 |=> ctrl_out[3:0] == $past(req.latch))
        else $error("control write lost");
    a_row_range: assert property (@(posedge mclk) disable iff (!rst_n)
        req.wr && row[2] |-> dm.we && col == dm.addr[3:0])
        else $error("upper row not aliased");

    // ------------------------------------------------------------
    // request steps shared by the transfer checks below, single-edge and one-edge-later alike
    // ------------------------------------------------------------

    sequence s_ctrl_read;
        req.rd && !is_alias;
    endsequence

    sequence s_alias_read;
        req.rd && is_alias;
    endsequence

    sequence s_ctrl_write;
        req.wr && !is_alias;
    endsequence

    sequence s_alias_write;
        req.wr && is_alias;
    endsequence

    sequence s_idle;
        !req.wr;
    endsequence

    sequence s_latch_load;
        latch_we;
    endsequence

    sequence s_unused_read;
        req.rd && !is_alias && !hit_impl;
    endsequence

    sequence s_ro_read;
        req.rd && !is_alias && hit_impl && !WR_MAP[idx];
    endsequence

    // ------------------------------------------------------------
    // transfer checks: request, then latch, latch pulse or nibble one edge later; memory port in the same cycle
    // ------------------------------------------------------------
    a_ctrl_read_data: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ctrl_read |=> s_latch_load ##0 (latch_data == $past(cell_rd[idx])))
        else $error("control read did not reach latch");

    a_alias_read_data: assert property (@(posedge mclk) disable iff (!rst_n)
        s_alias_read |=> s_latch_load ##0 (latch_data == $past(dm_rdata)))
        else $error("aliased read did not reach latch");

    a_ctrl_write_data: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ctrl_write ##0 hit_wr |=> ctrl_out[$past(idx)*4 +: 4] == $past(req.latch))
        else $error("control write did not land");

    a_alias_no_ctrl: assert property (@(posedge mclk) disable iff (!rst_n)
        s_alias_write |=> $stable(ctrl_out))
        else $error("aliased write touched control space");

    a_alias_port: assert property (@(posedge mclk) disable iff (!rst_n)
        s_alias_write |-> dm.we && dm.addr == req.addr[5:0] && dm.wdata == req.latch)
        else $error("aliased write not passed to memory");

    a_ctrl_no_mem: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ctrl_write |-> !dm.we)
        else $error("control write reached memory");

    a_unused_read: assert property (@(posedge mclk) disable iff (!rst_n)
        s_unused_read |=> latch_data == ncr_pkg::UNUSED_READ_VAL)
        else $error("unused read value wrong");

    a_ro_read: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ro_read |=> latch_data == $past(ro_status[idx]))
        else $error("read-only value not returned");

    a_tmr_stored: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ctrl_write ##0 (idx == ncr_pkg::TMR_RESTART_ADDR) |=>
        ctrl_out[ncr_pkg::TMR_RESTART_ADDR*4 + ncr_pkg::TMR_RESTART_BIT] ==
        $past(req.latch[ncr_pkg::TMR_RESTART_BIT]))
        else $error("restart flag write not kept");

    a_idle_still: assert property (@(posedge mclk) disable iff (!rst_n)
        s_idle |=> $stable(ctrl_out))
        else $error("control changed without write");

    a_idle_no_mem: assert property (@(posedge mclk) disable iff (!rst_n)
        s_idle |-> !dm.we)
        else $error("memory write without request");

    a_latch_pulse: assert property (@(posedge mclk) disable iff (!rst_n)
        s_latch_load |-> $past(req.rd))
        else $error("latch load without read");

    a_ctrl_no_latch: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ctrl_write |=> !latch_we)
        else $error("write loaded the latch");

    a_refused_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        s_ctrl_write ##0 !hit_wr |=> ctrl_out[$past(idx)*4 +: 4] == 4'h0)
        else $error("refused location shows a value");
endmodule

// file: sim/ncr_dmem.sv
/*
 data memory stand-in behind the aliased upper half.
 assumes one clock; reads answer in the same cycle.
*/
`timescale 1ns/1ps
module ncr_dmem (
    input  wire logic             mclk,
    input  wire ncr_pkg::ncr_dm_t dm,
    output logic [3:0]            rdata
);
    logic [3:0] mem [64];
    initial foreach (mem[i]) mem[i] = 4'h0;
    assign rdata = mem[dm.addr];
    always @(posedge mclk) if (dm.we) mem[dm.addr] <= dm.wdata;
endmodule

// file: sim/tb.sv
/*
 self-checking bench for the nibble control register file.
 assumes ncr_dmem answers the aliased half; one request per cycle.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
    localparam logic [63:0] IMPL = 64'h0000_0000_007f_1fff;
    localparam logic [63:0] WRM  = 64'h0000_0000_0037_0fff;
    logic              mclk = 1'b0;
    logic              rst_n = 1'b0;
    ncr_pkg::ncr_req_t req = '0;
    logic [3:0]        ro_status [64];
    logic [3:0]        dm_rdata;
    ncr_pkg::ncr_dm_t  dm;
    logic              latch_we;
    logic [3:0]        latch_data;
    logic [255:0]      ctrl_out;
    logic [255:0]      exp_ctrl;
    logic [3:0]        prev_exp;
    bit                prev_rd = 0;
    int                failures = 0;
    int                check_count = 0;
    int                cm [64];
    int                am [64];
    initial forever #5 mclk = ~mclk;
    ncr_regfile #(.LARGE(1'b1), .IMPL_LARGE(IMPL), .WR_MAP(WRM)) dut_u (.mclk(mclk), .rst_n(rst_n), .req(req),
        .dm_rdata(dm_rdata), .ro_status(ro_status), .dm(dm), .latch_we(latch_we), .latch_data(latch_data),
        .ctrl_out(ctrl_out));
    ncr_dmem mem_u (.mclk(mclk), .dm(dm), .rdata(dm_rdata));
    // unused control places read 0 here by choice; bit 2 of 11h never reads back
    function automatic logic [3:0] rdv(int a);
        if (a >= 64) return am[a-64][3:0];
        if (!IMPL[a]) return 4'h0;
        if (!WRM[a]) return ro_status[a];
        return (a == 'h11) ? (cm[a][3:0] & 4'hb) : cm[a][3:0];
    endfunction
    task automatic step(bit r, bit w, logic [6:0] a, logic [3:0] d);
        @(posedge mclk);
        req <= '{rd: r, wr: w, addr: a, latch: d};
        #1;
        `CHK(latch_we, prev_rd)
        if (prev_rd) `CHK(latch_data, prev_exp)
        for (int n = 0; n < 64; n++) exp_ctrl[4*n +: 4] = (IMPL[n] && WRM[n]) ? cm[n][3:0] : 4'h0;
        `CHK(ctrl_out & ~(256'h4 << 68), exp_ctrl & ~(256'h4 << 68))
        `CHK(dm.we, w && a[6])
        if (a[6]) `CHK(dm.addr, a[5:0])
        prev_rd = r;
        prev_exp = rdv(a);
        if (w && a[6]) am[a[5:0]] = d;
        else if (w && IMPL[a[5:0]] && WRM[a[5:0]]) cm[a[5:0]] = d;
    endtask
    task automatic print_verdict();
        $display("counts: checks=%0d mismatches=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
    initial begin
        foreach (ro_status[i]) ro_status[i] = 4'h0;
        foreach (cm[i]) cm[i] = 0;
        foreach (am[i]) am[i] = 0;
        void'($urandom(56017));
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        foreach (ro_status[i]) ro_status[i] <= 4'($urandom);
        // full sweep of both halves, back to back, all 128 places
        for (int b = 0; b < 128; b += 64) begin
            for (int a = 0; a < 64; a++) step(0, 1, 7'(b + a), 4'($urandom));
            for (int a = 0; a < 64; a++) step(1, 0, 7'(b + a), 4'h0);
            $display("test sweep base %h done", b);
        end
        for (int i = 0; i < 300; i++) begin
            int k;
            k = $urandom_range(2, 0);
            step(k == 1, k == 2, 7'($urandom), 4'($urandom));
        end
        $display("test random mix done");
        step(0, 0, 7'h00, 4'h0);
        @(posedge mclk);
        rst_n <= 1'b0;
        @(posedge mclk);
        #1;
        `CHK(ctrl_out, 256'h0)
        @(posedge mclk);
        rst_n <= 1'b1;
        foreach (cm[i]) cm[i] = 0;
        step(1, 0, 7'h11, 4'h0);
        step(0, 0, 7'h00, 4'h0);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
